/* verilog/iowd_pkg.sv */
package iowd_pkg;
   // ==========================================
   // Port map
   localparam logic [15:0] IOWD_PORT_ADDR    = 16'h0443;
   localparam logic [7:0]  IOWD_CODE_MIN     = 8'h01;
   localparam logic [7:0]  IOWD_CODE_MAX     = 8'h3E;
   localparam logic [7:0]  IOWD_INTERVAL_RST = 8'h00;
   // ==========================================
   // Timing
   localparam int unsigned IOWD_CLK_HZ       = 40_000_000;
   localparam int unsigned IOWD_TICK_SEC     = 1;
   localparam int unsigned IOWD_TICK_CYCLES  = IOWD_CLK_HZ * IOWD_TICK_SEC;
   localparam int unsigned IOWD_SYNC_DEPTH   = 3;
   // ==========================================
   // Carrier for one host I/O access
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } iowd_io_req_t;

   typedef enum logic [1:0] {
      IOWD_CMD_NONE,
      IOWD_CMD_LOAD,
      IOWD_CMD_STOP
   } iowd_cmd_t;
endpackage : iowd_pkg

/* verilog/iowd_tick_gen.sv */
`timescale 1ns/1ps
// ==========================================
// One-second tick, restarted on every load
module iowd_tick_gen #(
   parameter int unsigned TICK_CYCLES = iowd_pkg::IOWD_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_b,
   // Control
   input  wire logic restart,
   input  wire logic run,
   // Tick
   output logic      tick
);
   localparam int unsigned CW = $clog2(TICK_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (restart || !run) begin
         cnt_nxt = '0;
      end else if (cnt_r == LAST) begin
         cnt_nxt = '0;
      end else begin
         cnt_nxt = cnt_r + CW'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign tick = run && !restart && (cnt_r == LAST);
endmodule : iowd_tick_gen

/* verilog/iowd_top.sv */
`timescale 1ns/1ps
// Behaviour
// - One I/O port at 443h; a write loads the interval and starts counting.
// - Codes 01h..3Eh give 1..62 seconds; host writes only these.
// - Each further write reloads the countdown with the new interval.
// - A read of the port stops and disarms the countdown.
// - Armed countdown expiring unrefreshed resets processor or raises interrupt.
module iowd_top #(
   parameter int unsigned TICK_CYCLES = iowd_pkg::IOWD_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   // Host I/O access, one cycle strobes on sys_clk
   input  wire logic [15:0] io_addr,
   input  wire logic [7:0]  io_wdata,
   input  wire logic        io_wr,
   input  wire logic        io_rd,
   output logic [7:0]       io_rdata,
   output logic             io_sel,
   // Expiry action select pin: 0 reset, 1 interrupt
   input  wire logic        act_irq_pin,
   // Status and expiry outputs
   output logic             armed,
   output logic [7:0]       interval,
   output logic             cpu_reset_req,
   output logic             cpu_irq_req
);
   // ==========================================
   // Access decode
   iowd_pkg::iowd_io_req_t req;
   iowd_pkg::iowd_cmd_t    cmd;

   function automatic logic hit(input logic [15:0] a);
      hit = (a == iowd_pkg::IOWD_PORT_ADDR);
   endfunction : hit

   assign req = '{addr: io_addr, wdata: io_wdata, wr: io_wr, rd: io_rd};
   assign io_sel = hit(req.addr) && (req.wr || req.rd);

   always_comb begin
      cmd = iowd_pkg::IOWD_CMD_NONE;
      if (hit(req.addr) && req.rd) begin
         cmd = iowd_pkg::IOWD_CMD_STOP;
      end else if (hit(req.addr) && req.wr) begin
         cmd = iowd_pkg::IOWD_CMD_LOAD;
      end
   end

   // ==========================================
   // Action select pin: three-stage synchroniser
   logic [2:0] sel_sync_r;
   logic [2:0] sel_sync_nxt;
   logic       sel_irq_r;
   logic       sel_irq_nxt;

   always_comb begin
      sel_sync_nxt = {sel_sync_r[1:0], act_irq_pin};
      sel_irq_nxt  = sel_irq_r;
      if (sel_sync_r[1] == sel_sync_r[2]) begin
         sel_irq_nxt = sel_sync_r[2];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         sel_sync_r <= 3'h0;
         sel_irq_r  <= 1'b0;
      end else begin
         sel_sync_r <= sel_sync_nxt;
         sel_irq_r  <= sel_irq_nxt;
      end
   end

   // ==========================================
   // Countdown
   logic       armed_r;
   logic       armed_nxt;
   logic [7:0] remain_r;
   logic [7:0] remain_nxt;
   logic [7:0] ivl_r;
   logic [7:0] ivl_nxt;
   logic       rst_req_r;
   logic       rst_req_nxt;
   logic       irq_r;
   logic       irq_nxt;
   logic       tick;
   logic       expire;

   iowd_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .restart (cmd == iowd_pkg::IOWD_CMD_LOAD),
      .run     (armed_r),
      .tick    (tick)
   );

   assign expire = armed_r && tick && (remain_r == 8'h01);

   always_comb begin
      armed_nxt   = armed_r;
      remain_nxt  = remain_r;
      ivl_nxt     = ivl_r;
      rst_req_nxt = rst_req_r;
      irq_nxt     = irq_r;
      case (cmd)
         iowd_pkg::IOWD_CMD_LOAD: begin
            // Code 00h would wrap to FFh at the first tick; treat as a stop instead
            ivl_nxt    = req.wdata;
            remain_nxt = req.wdata;
            armed_nxt  = (req.wdata != 8'h00);
            irq_nxt    = 1'b0;
         end
         iowd_pkg::IOWD_CMD_STOP: begin
            armed_nxt = 1'b0;
            irq_nxt   = 1'b0;
         end
         default: begin
            if (expire) begin
               armed_nxt = 1'b0;
               remain_nxt = 8'h00;
               if (sel_irq_r) begin
                  irq_nxt = 1'b1;
               end else begin
                  rst_req_nxt = 1'b1;
               end
            end else if (armed_r && tick) begin
               remain_nxt = remain_r - 8'h01;
            end
         end
      endcase
      // Reset pulse lasts one cycle; system reset follows outside
      if (rst_req_r) begin
         rst_req_nxt = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         armed_r   <= 1'b0;
         remain_r  <= iowd_pkg::IOWD_INTERVAL_RST;
         ivl_r     <= iowd_pkg::IOWD_INTERVAL_RST;
         rst_req_r <= 1'b0;
         irq_r     <= 1'b0;
      end else begin
         armed_r   <= armed_nxt;
         remain_r  <= remain_nxt;
         ivl_r     <= ivl_nxt;
         rst_req_r <= rst_req_nxt;
         irq_r     <= irq_nxt;
      end
   end

   // ==========================================
   // Read data: interval last written
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   always_comb begin
      rdata_nxt = rdata_r;
      if (cmd == iowd_pkg::IOWD_CMD_STOP) begin
         rdata_nxt = ivl_r;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign io_rdata      = rdata_r;
   assign armed         = armed_r;
   assign interval      = ivl_r;
   assign cpu_reset_req = rst_req_r;
   assign cpu_irq_req   = irq_r;

   // ==========================================
   // Checks
   sequence s_port_write;
      hit(io_addr) && io_wr && !io_rd && (io_wdata != 8'h00);
   endsequence

   sequence s_port_read;
      hit(io_addr) && io_rd;
   endsequence

   // Reset request is a single-cycle pulse
   sequence s_rst_pulse;
      rst_req_r ##1 !rst_req_r;
   endsequence

   a_write_arms: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_port_write |=> armed_r && (remain_r == $past(io_wdata)))
      else $error("Write did not arm with written interval");

   a_write_reload: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_port_write |=> (ivl_r == $past(io_wdata)))
      else $error("Write did not reload interval");

   a_read_stops: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_port_read |=> !armed_r && !irq_r)
      else $error("Read did not disarm");

   a_no_act_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !armed_r && !tick |=> !$rose(rst_req_r) && !$rose(irq_r))
      else $error("Expiry action while disarmed");

   a_expire_rst: assert property (@(posedge sys_clk) disable iff (!rst_b)
      expire && !sel_irq_r && cmd == iowd_pkg::IOWD_CMD_NONE
      |=> s_rst_pulse)
      else $error("Reset pulse missing on expiry");

   a_expire_irq: assert property (@(posedge sys_clk) disable iff (!rst_b)
      expire && sel_irq_r && cmd == iowd_pkg::IOWD_CMD_NONE
      |=> irq_r && !rst_req_r)
      else $error("Interrupt missing on expiry");

   a_code_range: assert property (@(posedge sys_clk) disable iff (!rst_b)
      armed_r |-> (remain_r != 8'h00) && (remain_r <= ivl_r))
      else $error("Remaining count outside written interval");

   a_count_down: assert property (@(posedge sys_clk) disable iff (!rst_b)
      armed_r && tick && remain_r > 8'h01 && cmd == iowd_pkg::IOWD_CMD_NONE
      |=> remain_r == $past(remain_r) - 8'h01)
      else $error("Countdown did not step");

   a_reset_disarm: assert property (@(posedge sys_clk)
      !rst_b |=> !armed_r && !cpu_reset_req && !cpu_irq_req)
      else $error("Not disarmed after reset");
endmodule : iowd_top

/* tb/iowd_host.sv */
`timescale 1ns/1ps
// ==========================================
// Host processor side of the watchdog port
module iowd_host (
   // Clock
   input  wire logic        sys_clk,
   // Host I/O access
   output logic [15:0]      io_addr,
   output logic [7:0]       io_wdata,
   output logic             io_wr,
   output logic             io_rd,
   input  wire logic [7:0]  io_rdata
);
   initial begin
      io_addr  = 16'hFFFF;
      io_wdata = 8'hFF;
      io_wr    = 1'b0;
      io_rd    = 1'b0;
   end

   // Idle lines show the inverse, so no stale value can match
   task automatic idle_bus();
      io_addr  = ~io_addr;
      io_wdata = ~io_wdata;
      io_wr    = 1'b0;
      io_rd    = 1'b0;
   endtask : idle_bus

   // Caller passes codes 01h..3Eh; expire() then lets the count run out unrefreshed
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      io_addr  = a;
      io_wdata = d;
      io_wr    = 1'b1;
      @(negedge sys_clk);
      idle_bus();
   endtask : wr

   // Only way the host turns the timer off
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      io_addr = a;
      io_rd   = 1'b1;
      @(negedge sys_clk);
      d = io_rdata;
      idle_bus();
   endtask : rd
endmodule : iowd_host

/* tb/test_io_port_watchdog_timer.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
   fail_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_io_port_watchdog_timer;
   localparam int unsigned TICK = 10;
   localparam logic [15:0] PA   = iowd_pkg::IOWD_PORT_ADDR;
   logic        sys_clk, rst_b, io_wr, io_rd, io_sel, act_irq_pin;
   logic        armed, cpu_reset_req, cpu_irq_req;
   logic [15:0] io_addr;
   logic [7:0]  io_wdata, io_rdata, interval, rdv;
   int          fail_count  = 0;
   int          checks_done = 0;

   iowd_top #(.TICK_CYCLES(TICK)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
      .io_rdata(io_rdata), .io_sel(io_sel), .act_irq_pin(act_irq_pin),
      .armed(armed), .interval(interval), .cpu_reset_req(cpu_reset_req),
      .cpu_irq_req(cpu_irq_req));
   iowd_host u_host (.sys_clk(sys_clk), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata));

   initial sys_clk = 1'b0;
   always #12.5 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      if (rst_b && (io_wr || io_rd)) `CHK("io_sel", io_addr == PA, io_sel)
   end

   task automatic wrap_up();
      if (fail_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   // Load a code and time the expiry from the cycle after the strobe
   task automatic expire(input logic [7:0] code);
      int cnt;
      int exp_c;
      cnt   = 0;
      exp_c = int'(code) * TICK;
      u_host.wr(PA, code);
      while (cpu_reset_req !== 1'b1 && cpu_irq_req !== 1'b1 && cnt < 700) begin
         @(negedge sys_clk);
         cnt++;
      end
      `CHK("expiry time", 1'b1, (cnt >= exp_c - 1 && cnt <= exp_c + 1))
      @(negedge sys_clk);
      `CHK("armed after expiry", 1'b0, armed)
   endtask : expire

   initial begin
      rst_b       = 1'b0;
      act_irq_pin = 1'b0;
      repeat (5) @(negedge sys_clk);
      rst_b = 1'b1;
      @(negedge sys_clk);
      `CHK("armed at reset", 1'b0, armed)
      `CHK("irq at reset", 1'b0, cpu_irq_req)
      u_host.wr(16'h0444, 8'h05);
      `CHK("armed by other port", 1'b0, armed)
      u_host.wr(PA, 8'h02);
      `CHK("armed by write", 1'b1, armed)
      `CHK("interval", 8'h02, interval)
      // Reload before the 2 s run out; expiry must follow the new code
      repeat (15) @(negedge sys_clk);
      expire(8'h04);
      `CHK("reset pulse width", 1'b0, cpu_reset_req)
      expire(8'h01);
      expire(8'h3E);
      u_host.wr(PA, 8'h01);
      u_host.rd(PA, rdv);
      `CHK("read data", 8'h01, rdv)
      `CHK("armed after read", 1'b0, armed)
      repeat (30) begin
         @(negedge sys_clk);
         `CHK("no action after read", 1'b0, cpu_reset_req)
      end
      // System reset in mid-count must cancel the pending expiry
      u_host.wr(PA, 8'h03);
      rst_b = 1'b0;
      repeat (2) @(negedge sys_clk);
      rst_b = 1'b1;
      `CHK("armed after reset", 1'b0, armed)
      `CHK("interval after reset", iowd_pkg::IOWD_INTERVAL_RST, interval)
      repeat (40) begin
         @(negedge sys_clk);
         `CHK("no action after reset", 1'b0, cpu_reset_req)
      end
      `CHK("still disarmed", 1'b0, armed)
      // Pin settles through the synchroniser before the next load
      act_irq_pin = 1'b1;
      repeat (5) @(negedge sys_clk);
      expire(8'h02);
      `CHK("irq level", 1'b1, cpu_irq_req)
      `CHK("no reset in irq mode", 1'b0, cpu_reset_req)
      u_host.rd(PA, rdv);
      `CHK("irq cleared", 1'b0, cpu_irq_req)
      wrap_up();
   end

   initial begin
      #(25 * 4000);
      fail_count++;
      wrap_up();
   end
endmodule : test_io_port_watchdog_timer
